//--- design/ckd_map.vh
// register offsets, field positions, reset values and counts of the clock distribution block
`ifndef CKD_MAP_VH
`define CKD_MAP_VH
`define CKD_OFS_SHADOW_LOW     8'h00
`define CKD_OFS_SHADOW_HIGH    8'h04
`define CKD_OFS_DIG_MASK       8'h08
`define CKD_OFS_ANA_MASK       8'h0C
`define CKD_OFS_UPDATE_CTRL    8'h10
`define CKD_OFS_TREE_ENABLES   8'h14
`define CKD_OFS_STATUS         8'h18
`define CKD_OFS_TREE_BASE      8'h40
`define CKD_OFS_TREE_LAST      8'h70
`define CKD_N_TREES            13
`define CKD_N_DIG              8
`define CKD_N_ANA              4
`define CKD_BUS_TREE           12
`define CKD_N_SRC              8
`define CKD_N_PIN              11
`define CKD_N_TAPS             21
`define CKD_TAP_MAX            5'h14
`define CKD_UPD_COMMIT_BIT     0
`define CKD_UPD_ALIGN_BIT      1
`define CKD_CFG2_SRC_LSB       16
`define CKD_CFG2_RESAMPLE_BIT  19
`define CKD_CFG2_PASSTHRU_BIT  22
`define CKD_CFG3_TAP_LSB       24
`define CKD_ST_SLEEP_BIT       0
`define CKD_ST_REFUSED_BIT     1
`define CKD_ST_DIGTAP_LSB      4
`define CKD_RST_PERIOD         16'h0000
`define CKD_RST_CFG_BYTE       8'h00
`define CKD_RST_ENABLES        13'h0000
`define CKD_RST_MASK8          8'h00
`endif

//--- design/ckd_clock_dist.v
// clock distribution back end: dividers, tap selection, resample and atomic update
`include "ckd_map.vh"
`default_nettype none

module ckd_clock_dist
(
   input  wire        clk_sys,
   input  wire        rst_n,
   input  wire [7:0]  avs_address,
   input  wire        avs_read,
   input  wire        avs_write,
   input  wire [31:0] avs_writedata,
   input  wire [3:0]  avs_byteenable,
   output reg  [31:0] avs_readdata,
   output reg         avs_waitrequest,
   input  wire [7:0]  src_clk_pin,
   input  wire [3:0]  nonvolatile_latch,
   input  wire        sleep_req_pin,
   input  wire        xtal_enabled_pin,
   input  wire        pll_enabled_pin,
   output wire [12:0] tree_clk_out,
   output reg         sleep_active
);

   // pick one tap of the delay chain, clamped to the last tap
   function tap_pick;
      input [20:0] chain;
      input [4:0]  idx;
      reg   [4:0]  k;
      begin
         k = (idx > `CKD_TAP_MAX) ? `CKD_TAP_MAX : idx;
         tap_pick = chain[k];
      end
   endfunction

   // byte lane merge for partial writes
   function [7:0] lane;
      input [7:0] old;
      input [7:0] new_b;
      input       en;
      begin
         lane = en ? new_b : old;
      end
   endfunction

   reg  [7:0]  shadow_period_low;
   reg  [7:0]  shadow_period_high;
   reg  [7:0]  digital_divider_select_mask;
   reg  [7:0]  analog_divider_select_mask;
   reg  [12:0] power_manager_tree_enables;
   reg  [15:0] period_reg [0:12];
   reg  [7:0]  cfg2_reg   [0:12];
   reg  [7:0]  cfg3_reg   [0:12];
   reg  [12:0] align_reg;
   reg  [3:0]  digital_tap_setting;
   reg         tap_captured_reg;
   reg  [3:0]  analog_tap_setting [0:3];
   reg         refused_reg;
   reg         sync_reg;
   reg  [20:0] chain_reg;
   reg  [10:0] pin_s1_reg;
   reg  [10:0] pin_s2_reg;
   reg  [10:0] pin_s3_reg;
   reg  [10:0] pin_lvl_reg;
   reg         sleep_prev_reg;

   wire [12:0] sel_mask = {1'b0, analog_divider_select_mask[3:0], digital_divider_select_mask};
   wire [15:0] shadow   = {shadow_period_high, shadow_period_low};
   wire        wr_now   = avs_write & ~avs_waitrequest;
   wire        rd_take  = (avs_read | avs_write) & avs_waitrequest;
   wire        is_tree  = (avs_address >= `CKD_OFS_TREE_BASE) &&
                          (avs_address <= `CKD_OFS_TREE_LAST) && (avs_address[1:0] == 2'h0);
   wire [3:0]  tree_idx = avs_address[5:2];
   wire        commit   = wr_now && (avs_address == `CKD_OFS_UPDATE_CTRL) &&
                          avs_byteenable[0] && avs_writedata[`CKD_UPD_COMMIT_BIT];
   wire        align    = wr_now && (avs_address == `CKD_OFS_UPDATE_CTRL) &&
                          avs_byteenable[0] && avs_writedata[`CKD_UPD_ALIGN_BIT];
   wire [7:0]  src_lvl  = pin_lvl_reg[7:0];
   wire        sleep_lvl = pin_lvl_reg[8];
   wire        xtal_lvl  = pin_lvl_reg[9];
   wire        pll_lvl   = pin_lvl_reg[10];

   // pins pass three flops; a level is taken once the second and third agree
   always @(posedge clk_sys)
   begin
      if (!rst_n)
      begin
         pin_s1_reg  <= 11'h000;
         pin_s2_reg  <= 11'h000;
         pin_s3_reg  <= 11'h000;
         pin_lvl_reg <= 11'h000;
      end
      else
      begin
         pin_s1_reg  <= {pll_enabled_pin, xtal_enabled_pin, sleep_req_pin, src_clk_pin};
         pin_s2_reg  <= pin_s1_reg;
         pin_s3_reg  <= pin_s2_reg;
         pin_lvl_reg <= (pin_s2_reg & ~(pin_s2_reg ^ pin_s3_reg)) |
                        (pin_lvl_reg & (pin_s2_reg ^ pin_s3_reg));
      end
   end

   // sync clock at half the system rate feeding a 21-stage delay chain
   always @(posedge clk_sys)
   begin
      if (!rst_n)
      begin
         sync_reg  <= 1'b0;
         chain_reg <= 21'h000000;
      end
      else
      begin
         sync_reg  <= ~sync_reg;
         chain_reg <= {chain_reg[19:0], sync_reg};
      end
   end

   // digital tap is caught from the latch once after reset release and never rewritten
   always @(posedge clk_sys)
   begin
      if (!rst_n)
      begin
         digital_tap_setting <= 4'h0;
         tap_captured_reg    <= 1'b0;
      end
      else if (!tap_captured_reg)
      begin
         digital_tap_setting <= nonvolatile_latch;
         tap_captured_reg    <= 1'b1;
      end
   end

   // live analog taps follow their config only while the analog tree is off
   genvar a;
   generate
      for (a = 0; a < `CKD_N_ANA; a = a + 1)
      begin : g_atap
         always @(posedge clk_sys)
         begin
            if (!rst_n)
               analog_tap_setting[a] <= 4'h0;
            else if (!power_manager_tree_enables[`CKD_N_DIG + a])
               analog_tap_setting[a] <= cfg3_reg[`CKD_N_DIG + a][3:0];
         end
      end
   endgenerate

   // sleep entry; a request with crystal or PLL running is refused and noted
   always @(posedge clk_sys)
   begin
      if (!rst_n)
      begin
         sleep_active   <= 1'b0;
         sleep_prev_reg <= 1'b0;
         refused_reg    <= 1'b0;
      end
      else
      begin
         sleep_prev_reg <= sleep_lvl;
         if (!sleep_lvl)
            sleep_active <= 1'b0;
         else if (!sleep_prev_reg && !xtal_lvl && !pll_lvl)
            sleep_active <= 1'b1;
         if (sleep_lvl && !sleep_prev_reg && (xtal_lvl || pll_lvl))
            refused_reg <= 1'b1;
         else if (wr_now && (avs_address == `CKD_OFS_STATUS) && avs_byteenable[0] &&
                  avs_writedata[`CKD_ST_REFUSED_BIT])
            refused_reg <= 1'b0;
      end
   end

   // register writes, commit and align
   integer i;
   always @(posedge clk_sys)
   begin
      if (!rst_n)
      begin
         shadow_period_low           <= `CKD_RST_MASK8;
         shadow_period_high          <= `CKD_RST_MASK8;
         digital_divider_select_mask <= `CKD_RST_MASK8;
         analog_divider_select_mask  <= `CKD_RST_MASK8;
         power_manager_tree_enables  <= `CKD_RST_ENABLES;
         align_reg                   <= 13'h0000;
         for (i = 0; i < `CKD_N_TREES; i = i + 1)
         begin
            period_reg[i] <= `CKD_RST_PERIOD;
            cfg2_reg[i]   <= `CKD_RST_CFG_BYTE;
            cfg3_reg[i]   <= `CKD_RST_CFG_BYTE;
         end
      end
      else
      begin
         align_reg <= align ? sel_mask : 13'h0000;
         if (wr_now && avs_byteenable[0])
         begin
            if (avs_address == `CKD_OFS_SHADOW_LOW)
               shadow_period_low <= avs_writedata[7:0];
            if (avs_address == `CKD_OFS_SHADOW_HIGH)
               shadow_period_high <= avs_writedata[7:0];
            if (avs_address == `CKD_OFS_DIG_MASK)
               digital_divider_select_mask <= avs_writedata[7:0];
            if (avs_address == `CKD_OFS_ANA_MASK)
               analog_divider_select_mask <= {4'h0, avs_writedata[3:0]};
         end
         if (wr_now && (avs_address == `CKD_OFS_TREE_ENABLES))
         begin
            power_manager_tree_enables[7:0] <= lane(power_manager_tree_enables[7:0],
                                                    avs_writedata[7:0], avs_byteenable[0]);
            if (avs_byteenable[1])
               power_manager_tree_enables[12:8] <= avs_writedata[12:8];
         end
         if (align)
            power_manager_tree_enables <= power_manager_tree_enables | sel_mask;
         if (wr_now && is_tree && (tree_idx < `CKD_N_TREES))
         begin
            // byte-wise writes stand on software keeping the tree disabled
            period_reg[tree_idx] <= {lane(period_reg[tree_idx][15:8], avs_writedata[15:8],
                                          avs_byteenable[1]),
                                     lane(period_reg[tree_idx][7:0], avs_writedata[7:0],
                                          avs_byteenable[0])};
            cfg2_reg[tree_idx] <= lane(cfg2_reg[tree_idx], avs_writedata[23:16],
                                       avs_byteenable[2]);
            cfg3_reg[tree_idx] <= lane(cfg3_reg[tree_idx], avs_writedata[31:24],
                                       avs_byteenable[3]);
         end
         if (commit)
         begin
            for (i = 0; i < `CKD_N_TREES; i = i + 1)
               if (sel_mask[i])
                  period_reg[i] <= shadow;
         end
      end
   end

   // per-tree divider and output selection
   genvar t;
   generate
      for (t = 0; t < `CKD_N_TREES; t = t + 1)
      begin : g_tree
         wire [4:0] tsel;
         if ((t >= `CKD_N_DIG) && (t < `CKD_BUS_TREE))
         begin : g_ana
            assign tsel = {1'b0, analog_tap_setting[t - `CKD_N_DIG]};
         end
         else
         begin : g_dig
            assign tsel = {1'b0, digital_tap_setting};
         end
         wire       t_lvl = tap_pick(chain_reg, tsel);
         wire       s_lvl;
         reg        t_prev_reg;
         reg        s_prev_reg;
         reg        div_reg;
         reg        out_reg;
         reg [15:0] cnt_reg;
         wire       t_rise = t_lvl & ~t_prev_reg;
         if (t == `CKD_BUS_TREE)
         begin : g_bsrc
            assign s_lvl = t_lvl;
         end
         else
         begin : g_ssrc
            assign s_lvl = src_lvl[cfg2_reg[t][2:0]];
         end
         wire s_tick   = s_lvl & ~s_prev_reg;
         wire resample = cfg2_reg[t][3];
         wire passthru = cfg2_reg[t][6];
         wire live     = power_manager_tree_enables[t] & ~sleep_active;
         assign tree_clk_out[t] = out_reg;

         always @(posedge clk_sys)
         begin
            if (!rst_n)
            begin
               t_prev_reg <= 1'b0;
               s_prev_reg <= 1'b0;
               div_reg    <= 1'b0;
               out_reg    <= 1'b0;
               cnt_reg    <= `CKD_RST_PERIOD;
            end
            else
            begin
               t_prev_reg <= t_lvl;
               s_prev_reg <= s_lvl;
               if (!live)
               begin
                  cnt_reg <= period_reg[t];
                  div_reg <= 1'b0;
                  out_reg <= 1'b0;
               end
               else
               begin
                  if (align_reg[t])
                  begin
                     cnt_reg <= period_reg[t];
                     div_reg <= 1'b0;
                  end
                  else if (s_tick)
                  begin
                     if (cnt_reg == 16'h0000)
                     begin
                        cnt_reg <= period_reg[t];
                        div_reg <= 1'b1;
                     end
                     else
                     begin
                        cnt_reg <= cnt_reg - 16'h0001;
                        div_reg <= 1'b0;
                     end
                  end
                  if (passthru)
                     out_reg <= t_lvl;
                  else if (resample)
                  begin
                     if (t_rise)
                        out_reg <= (period_reg[t] == 16'h0000) ? s_lvl : div_reg;
                  end
                  else if (period_reg[t] != 16'h0000)
                     out_reg <= div_reg;
                  else
                     out_reg <= s_lvl;
               end
            end
         end
      end
   endgenerate

   // avalon slave: waitrequest drops for one cycle, read data loaded with it
   always @(posedge clk_sys)
   begin
      if (!rst_n)
      begin
         avs_waitrequest <= 1'b1;
         avs_readdata    <= 32'h00000000;
      end
      else
      begin
         avs_waitrequest <= ~rd_take;
         if (rd_take && avs_read)
         begin
            case (avs_address)
               `CKD_OFS_SHADOW_LOW:   avs_readdata <= {24'h000000, shadow_period_low};
               `CKD_OFS_SHADOW_HIGH:  avs_readdata <= {24'h000000, shadow_period_high};
               `CKD_OFS_DIG_MASK:     avs_readdata <= {24'h000000, digital_divider_select_mask};
               `CKD_OFS_ANA_MASK:     avs_readdata <= {24'h000000, analog_divider_select_mask};
               `CKD_OFS_UPDATE_CTRL:  avs_readdata <= 32'h00000000;
               `CKD_OFS_TREE_ENABLES: avs_readdata <= {19'h00000, power_manager_tree_enables};
               `CKD_OFS_STATUS:       avs_readdata <= {24'h000000, digital_tap_setting, 2'h0,
                                                       refused_reg, sleep_active};
               default:
               begin
                  if (is_tree && (tree_idx < `CKD_N_TREES))
                     avs_readdata <= {cfg3_reg[tree_idx], cfg2_reg[tree_idx],
                                      period_reg[tree_idx]};
                  else
                     avs_readdata <= 32'h00000000;
               end
            endcase
         end
      end
   end

endmodule // ckd_clock_dist

`default_nettype wire

//--- tb/ckd_clock_dist_properties.sv
// port-level assertion checker for the clock distribution block
`include "ckd_map.vh"
`default_nettype none
module ckd_clock_dist_properties
(
   input wire logic        clk_sys,
   input wire logic        rst_n,
   input wire logic [7:0]  avs_address,
   input wire logic        avs_read,
   input wire logic        avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0]  avs_byteenable,
   input wire logic [31:0] avs_readdata,
   input wire logic        avs_waitrequest,
   input wire logic [3:0]  nonvolatile_latch,
   input wire logic        sleep_req_pin,
   input wire logic        xtal_enabled_pin,
   input wire logic        pll_enabled_pin,
   input wire logic [12:0] tree_clk_out,
   input wire logic        sleep_active
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rst_n);

   sequence answered;
      !avs_waitrequest;
   endsequence
   sequence rd_req(logic [7:0] a);
      avs_read && avs_address == a && avs_waitrequest;
   endsequence
   sequence tree0_off;
      avs_write && avs_address == `CKD_OFS_TREE_ENABLES && avs_byteenable[0]
         && !avs_writedata[0] && !avs_waitrequest;
   endsequence

   a_wait_one_cycle: assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("waitrequest low for more than one cycle");
   a_req_answered: assert property ((avs_read || avs_write) && avs_waitrequest |=> answered)
      else $error("request not answered in the next cycle");
   a_no_spont_answer: assert property (!avs_waitrequest |-> $past(avs_read || avs_write))
      else $error("answer without a request");
   a_reset_quiet: assert property ($rose(rst_n) |-> avs_waitrequest
      && tree_clk_out == 13'h0000 && !sleep_active) else $error("outputs active after reset");
   a_ctrl_reads_zero: assert property (rd_req(`CKD_OFS_UPDATE_CTRL) ##1 answered
      |-> avs_readdata == 32'h0) else $error("update control reads nonzero");
   a_tap_readback: assert property (rd_req(`CKD_OFS_STATUS) ##1 answered
      |-> avs_readdata[7:4] == nonvolatile_latch) else $error("digital tap differs from strap");
   a_unmapped_zero: assert property (rd_req(8'h20) ##1 answered
      |-> avs_readdata == 32'h0) else $error("unmapped read nonzero");
   a_sleep_gates: assert property (sleep_active && $past(sleep_active)
      |-> tree_clk_out == 13'h0000) else $error("tree clock running in sleep");
   a_sleep_refused: assert property ((xtal_enabled_pin || pll_enabled_pin) [*8]
      |-> !$rose(sleep_active)) else $error("sleep entered with crystal or pll on");
   a_sleep_exit: assert property (!sleep_req_pin [*8] |-> !sleep_active)
      else $error("sleep held without request");
   a_disable_quiet: assert property (tree0_off |-> ##3 !tree_clk_out[0] [*4])
      else $error("disabled tree still toggles");
endmodule // ckd_clock_dist_properties

bind ckd_clock_dist ckd_clock_dist_properties u_props (.clk_sys(clk_sys), .rst_n(rst_n),
   .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
   .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
   .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
   .nonvolatile_latch(nonvolatile_latch), .sleep_req_pin(sleep_req_pin),
   .xtal_enabled_pin(xtal_enabled_pin), .pll_enabled_pin(pll_enabled_pin),
   .tree_clk_out(tree_clk_out), .sleep_active(sleep_active));
`default_nettype wire

//--- tb/ckd_periph_model.sv
// clock consumer model: measures each tree clock period in system clock cycles
`default_nettype none
module ckd_periph_model
(
   input  wire logic        clk_sys,
   input  wire logic        rst_n,
   input  wire logic [12:0] tree_clk,
   output var  logic [15:0] last_per [13]
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [15:0] cnt [13];
   logic [12:0] prev_reg;
   always @(posedge clk_sys)
   begin
      prev_reg <= tree_clk;
      for (int i = 0; i < 13; i++)
      begin
         // period counted from rising edge to rising edge of the consumed clock
         if (!rst_n || (tree_clk[i] && !prev_reg[i]))
         begin
            last_per[i] <= rst_n ? cnt[i] : 16'h0000;
            cnt[i]      <= 16'h0001;
         end
         else
            cnt[i] <= cnt[i] + 16'h0001;
      end
   end
endmodule // ckd_periph_model
`default_nettype wire

//--- tb/ckd_clock_dist_tb_top.sv
// self-checking bench for the clock distribution block
`include "ckd_map.vh"
`default_nettype none
module ckd_clock_dist_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   typedef struct {int tree; logic [31:0] cfg; logic [15:0] per;} ckd_row_t;
   logic        clk_sys = 1'b0;
   logic        rst_n = 1'b0;
   logic [7:0]  avs_address = 8'h00;
   logic        avs_read = 1'b0;
   logic        avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [3:0]  avs_byteenable = 4'hF;
   logic [31:0] avs_readdata;
   logic        avs_waitrequest;
   logic [7:0]  src_clk_pin = 8'h00;
   logic [3:0]  sc [8] = '{default: 4'h0};
   logic        sleep_req = 1'b0;
   logic        xtal_en = 1'b0;
   logic        pll_en = 1'b0;
   logic [12:0] tree_clk;
   logic        sleep_active;
   logic [15:0] last_per [13];
   logic [31:0] q;
   logic [7:0]  ra [5] = '{`CKD_OFS_TREE_ENABLES, `CKD_OFS_TREE_BASE, `CKD_OFS_UPDATE_CTRL,
                          8'h20, `CKD_OFS_STATUS};
   logic [31:0] re [5] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h90};
   ckd_row_t    rows [7];
   int          n_fail = 0;
   int          checks_done = 0;
   int          cyc = 0;

   always #50 clk_sys = ~clk_sys;

   // source pin k toggles every k+2 cycles, all derived from the bus clock
   always @(posedge clk_sys)
      for (int k = 0; k < 8; k++)
         if (sc[k] == 4'(k + 1))
         begin
            sc[k]          <= 4'h0;
            src_clk_pin[k] <= ~src_clk_pin[k];
         end
         else
            sc[k] <= sc[k] + 4'h1;

   ckd_clock_dist uut (.clk_sys(clk_sys), .rst_n(rst_n), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest),
      .src_clk_pin(src_clk_pin), .nonvolatile_latch(4'h9), .sleep_req_pin(sleep_req),
      .xtal_enabled_pin(xtal_en), .pll_enabled_pin(pll_en), .tree_clk_out(tree_clk),
      .sleep_active(sleep_active)); // strap fixed from power-up

   ckd_periph_model u_periph (.clk_sys(clk_sys), .rst_n(rst_n), .tree_clk(tree_clk),
      .last_per(last_per));

   function automatic logic [31:0] mk(input int m, input int src, input int rs, input int pt,
                                      input int tap);
      return 32'(m) | 32'(src) << `CKD_CFG2_SRC_LSB | 32'(rs) << `CKD_CFG2_RESAMPLE_BIT
         | 32'(pt) << `CKD_CFG2_PASSTHRU_BIT | 32'(tap) << `CKD_CFG3_TAP_LSB;
   endfunction

   function automatic logic [7:0] ta(input int n);
      return `CKD_OFS_TREE_BASE + 8'(4 * n);
   endfunction

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // one bus access, held until waitrequest is sampled low; read data lands in q
   task automatic av(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      avs_address   <= a;
      avs_writedata <= d;
      avs_write     <= wr;
      avs_read      <= !wr;
      do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
      q = avs_readdata;
      avs_write <= 1'b0;
      avs_read  <= 1'b0;
   endtask

   task automatic close_out;
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   // ceiling well above the roughly 1500 cycles the tests need
   always @(posedge clk_sys)
   begin
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         n_fail++;
         close_out;
      end
   end

   initial
   begin
      rows = '{'{0, mk(0, 1, 0, 0, 0), 6}, '{1, mk(4, 0, 0, 0, 0), 20},
               '{2, mk(2, 2, 1, 0, 0), 24}, '{8, mk(0, 5, 0, 1, 0), 2},
               '{12, mk(3, 0, 1, 0, 0), 8}, '{9, mk(1, 3, 0, 0, 5), 20},
               '{3, mk(1, 0, 0, 0, 0), 8}};
      repeat (10) @(posedge clk_sys);
      rst_n <= 1'b1;
      for (int i = 0; i < 5; i++)
      begin
         av(1'b0, ra[i], 32'h0);
         check(q, re[i]);
      end
      // partial lane writes to a tree that stays disabled
      avs_byteenable <= 4'h1;
      av(1'b1, ta(7), 32'hFFFFFF12);
      avs_byteenable <= 4'h2;
      av(1'b1, ta(7), 32'hFFFF34AB);
      avs_byteenable <= 4'hF;
      av(1'b0, ta(7), 32'h0);
      check(q, 32'h00003412);
      $display("reset values done");
      foreach (rows[i])
      begin
         av(1'b1, ta(rows[i].tree), rows[i].cfg);
         av(1'b0, ta(rows[i].tree), 32'h0);
         check(q, rows[i].cfg);
         av(1'b1, `CKD_OFS_TREE_ENABLES, 32'h1 << rows[i].tree);
         repeat (150) @(posedge clk_sys);
         check(last_per[rows[i].tree], rows[i].per);
         av(1'b1, `CKD_OFS_TREE_ENABLES, 32'h0);
         $display("tree row %0d done", i);
      end
      for (int n = 4; n < 7; n++)
         av(1'b1, ta(n), 32'h0);
      av(1'b1, `CKD_OFS_SHADOW_LOW, 32'h5);
      av(1'b1, `CKD_OFS_SHADOW_HIGH, 32'h0);
      av(1'b1, `CKD_OFS_DIG_MASK, 32'h30);
      av(1'b1, `CKD_OFS_UPDATE_CTRL, 32'h3);
      av(1'b0, `CKD_OFS_TREE_ENABLES, 32'h0);
      check(q, 32'h30);
      av(1'b0, ta(5), 32'h0);
      check(q, 32'h5);
      repeat (20)
      begin
         @(posedge clk_sys);
         check(tree_clk[4], tree_clk[5]);
      end
      av(1'b1, `CKD_OFS_SHADOW_HIGH, 32'h1);
      av(1'b1, `CKD_OFS_DIG_MASK, 32'h40);
      av(1'b1, `CKD_OFS_UPDATE_CTRL, 32'h1);
      av(1'b0, ta(6), 32'h0);
      check(q, 32'h105);
      av(1'b0, `CKD_OFS_TREE_ENABLES, 32'h0);
      check(q, 32'h30);
      // two full periods of tree 4 must have passed since the align restart
      repeat (30) @(posedge clk_sys);
      check(last_per[4], 16'h0018);
      av(1'b1, `CKD_OFS_SHADOW_HIGH, 32'h0);
      av(1'b1, `CKD_OFS_SHADOW_LOW, 32'h2);
      av(1'b1, `CKD_OFS_DIG_MASK, 32'h10);
      av(1'b1, `CKD_OFS_UPDATE_CTRL, 32'h1);
      repeat (80) @(posedge clk_sys);
      check(last_per[4], 16'h000C);
      av(1'b1, `CKD_OFS_TREE_ENABLES, 32'h20);
      repeat (4) @(posedge clk_sys);
      repeat (30)
      begin
         @(posedge clk_sys);
         check(tree_clk[4], 1'b0);
      end
      $display("shadow update done");
      for (int k = 0; k < 2; k++)
      begin
         xtal_en <= (k == 0);
         pll_en  <= (k == 1);
         repeat (12) @(posedge clk_sys);
         sleep_req <= 1'b1;
         repeat (12) @(posedge clk_sys);
         check(sleep_active, 1'b0);
         sleep_req <= 1'b0;
         repeat (12) @(posedge clk_sys);
         av(1'b0, `CKD_OFS_STATUS, 32'h0);
         check(q, 32'h92);
         av(1'b1, `CKD_OFS_STATUS, 32'h2);
      end
      xtal_en <= 1'b0;
      pll_en  <= 1'b0;
      av(1'b0, `CKD_OFS_STATUS, 32'h0);
      check(q, 32'h90);
      repeat (12) @(posedge clk_sys);
      sleep_req <= 1'b1;
      repeat (12) @(posedge clk_sys);
      check(sleep_active, 1'b1);
      check(tree_clk, 13'h0000);
      sleep_req <= 1'b0;
      repeat (12) @(posedge clk_sys);
      check(sleep_active, 1'b0);
      $display("sleep done");
      close_out;
   end
endmodule // ckd_clock_dist_tb_top
`default_nettype wire
